// ---- hpi_gate_seq.sv ----
// fast address gate sequencer
// assumes one-cycle host write pulses from the synchronised pins
`timescale 1ns/1ns
`default_nettype none
module hpi_gate_seq (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic enable,
  // host writes into the first input register
  input wire logic wr_pulse,
  input wire logic is_cmd,
  input wire logic [7:0] data,
  // results
  output logic swallow,
  output logic gate_out
);

  // ==========================================
  // state and gate level
  hpi_pkg::hpi_gate_state_t state_q;
  logic gate_q;

  // the byte is consumed by hardware, not software
  assign swallow = enable & (is_cmd ? (data == hpi_pkg::CMD_GATE)
                                    : (state_q == hpi_pkg::HPI_GS_ARMED));
  assign gate_out = gate_q;

  // command tracking
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_q <= hpi_pkg::HPI_GS_IDLE;
    else if (!enable)
      state_q <= hpi_pkg::HPI_GS_IDLE;
    else if (wr_pulse)
    begin
      case (state_q)
        hpi_pkg::HPI_GS_IDLE:
          // gate command arms the sequence
          state_q <= (is_cmd && data == hpi_pkg::CMD_GATE) ? hpi_pkg::HPI_GS_ARMED
                                                           : hpi_pkg::HPI_GS_IDLE;
        hpi_pkg::HPI_GS_ARMED:
          // repeated gate command retriggers, anything else ends it
          state_q <= (is_cmd && data == hpi_pkg::CMD_GATE) ? hpi_pkg::HPI_GS_ARMED
                                                           : hpi_pkg::HPI_GS_IDLE;
        default:
          state_q <= hpi_pkg::HPI_GS_IDLE;
      endcase
    end
  end

  // data byte after the command drives the gate from its bit 1
  always_ff @(posedge clk)
  begin
    if (!nrst)
      gate_q <= hpi_pkg::GATE_RESET;
    else if (enable && wr_pulse && !is_cmd && state_q == hpi_pkg::HPI_GS_ARMED)
      gate_q <= data[hpi_pkg::GATE_DATA_BIT];
  end

  // ==========================================
  // checks
  property p_gate_follows;
    @(posedge clk) disable iff (!nrst)
    (enable && wr_pulse && !is_cmd && state_q == hpi_pkg::HPI_GS_ARMED)
      |=> gate_q == $past(data[1]);
  endproperty
  a_gate_follows: assert property (p_gate_follows)
    else $error("gate did not follow data bit 1");

  property p_gate_hold;
    @(posedge clk) disable iff (!nrst)
    (state_q == hpi_pkg::HPI_GS_IDLE) |=> $stable(gate_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold)
    else $error("gate moved without a preceding command");

  c_gate_seq: cover property (@(posedge clk) disable iff (!nrst) $fell(gate_q));

endmodule : hpi_gate_seq
`default_nettype wire

// ---- hpi_host_model.sv ----
// host processor model for the parallel port of the interrupt block
// assumes the 50 MHz system clock only paces its strobes
`timescale 1ns/1ns
`default_nettype none
module hpi_host_model (
  // pacing clock
  input wire logic clk,
  // host pins
  output logic sel_a_n,
  output logic sel_b_n,
  output logic addr_bit,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data
);
  // ==========================================
  // idle pins at time zero
  initial
  begin
    sel_a_n = 1'b1;
    sel_b_n = 1'b1;
    addr_bit = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data = 8'h00;
  end

  // ==========================================
  // one host access; callers wait for it to end, so never two at once
  task automatic xfer(input logic pair_b, input logic a0, input logic is_wr,
                      input logic [7:0] d);
    // select, address and data settle before the strobe falls
    @(posedge clk);
    sel_a_n <= pair_b;
    sel_b_n <= !pair_b;
    addr_bit <= a0;
    data <= d;
    @(posedge clk);
    // strobe low long enough for the pin filter
    if (is_wr)
      wr_n <= 1'b0;
    else
      rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    // hold qualifiers past the rise, then release the bus
    repeat (5) @(posedge clk);
    sel_a_n <= 1'b1;
    sel_b_n <= 1'b1;
    data <= ~d;
    repeat (4) @(posedge clk);
    // hand back mid-cycle so callers never sample on a launching edge
    @(negedge clk);
  endtask : xfer
endmodule : hpi_host_model
`default_nettype wire

// ---- hpi_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins and one system clock
`timescale 1ns/1ns
`default_nettype none
module hpi_pin_sync #(
  parameter int unsigned W = 12,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins in, filtered levels out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  // ==========================================
  // synchroniser stages
  logic [W-1:0] s1_q;  // read only by s2_q
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;  // filtered level

  // shift stages
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes once stage two and three agree
  always_ff @(posedge clk)
  begin
    if (!nrst)
      lvl_q <= INIT;
    else
      lvl_q <= (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  end

  assign level = lvl_q;

endmodule : hpi_pin_sync
`default_nettype wire

// ---- hpi_pkg.sv ----
// shared constants of the host port interrupt block
// assumes a 50 MHz system clock and a synchronous active-low reset
package hpi_pkg;

  // ==========================================
  // slave register offsets (byte addresses)
  localparam logic [4:0] ADDR_CTRL = 5'h00;  // control bits
  localparam logic [4:0] ADDR_FLAGS = 5'h04;  // input-full flags
  localparam logic [4:0] ADDR_IN_A = 5'h08;  // first host input data
  localparam logic [4:0] ADDR_IN_B = 5'h0C;  // second host input data
  localparam logic [4:0] ADDR_PORT4 = 5'h10;  // port four output latch
  localparam logic [4:0] ADDR_EVT = 5'h14;  // sticky event status
  localparam logic [4:0] ADDR_MASK = 5'h18;  // event mask

  // ==========================================
  // control field positions
  localparam int unsigned CTRL_SLAVE_EN = 0;  // slave mode enable
  localparam int unsigned CTRL_FAST_GATE = 1;  // fast gate enable
  localparam int unsigned CTRL_IRQ_EN_A = 2;  // first input-full irq enable
  localparam int unsigned CTRL_IRQ_EN_B = 3;  // second input-full irq enable

  // ==========================================
  // port four latch positions of the host request lines
  localparam int unsigned LINE_B_BIT = 3;
  localparam int unsigned LINE_A_BIT = 4;
  localparam int unsigned LINE_C_BIT = 5;

  // ==========================================
  // event bit positions
  localparam int unsigned EVT_WR_A = 0;  // host wrote first input
  localparam int unsigned EVT_WR_B = 1;  // host wrote second input
  localparam int unsigned EVT_RD_A = 2;  // host read first output
  localparam int unsigned EVT_RD_B = 3;  // host read second output

  // ==========================================
  // reset values and command codes
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT4_RESET = 8'h00;
  localparam logic [3:0] EVT_RESET = 4'h0;
  localparam logic GATE_RESET = 1'b1;
  localparam logic [7:0] CMD_GATE = 8'hD1;  // gate command
  localparam int unsigned GATE_DATA_BIT = 1;  // data bit that drives the gate

  // gate sequencer states
  typedef enum logic [1:0] {
    HPI_GS_IDLE = 2'b01,
    HPI_GS_ARMED = 2'b10
  } hpi_gate_state_t;

endpackage : hpi_pkg

// ---- hpi_port.sv ----
// host port interrupt and request latch logic, slave side
// assumes host pins are asynchronous and the slave bus is on clk
`timescale 1ns/1ns
`default_nettype none
module hpi_port (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host pins
  input wire logic host_select_a_n,
  input wire logic host_select_b_n,
  input wire logic host_addr_bit,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [7:0] host_data_in,
  // slave register port
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // interrupts to the slave cpu
  output logic input_full_irq_a,
  output logic input_full_irq_b,
  output logic irq,
  // lines to the host
  output logic host_irq_line_a,
  output logic host_irq_line_b,
  output logic host_irq_line_c,
  output logic addr_gate_out
);

  // ==========================================
  // pin synchronisation
  logic [12:0] pins_f;  // filtered pin levels
  logic rd_n_f;
  logic wr_n_f;
  logic sel_a_n_f;
  logic sel_b_n_f;
  logic addr_f;
  logic [7:0] data_f;
  logic rd_prev_q;  // previous read strobe level
  logic wr_prev_q;  // previous write strobe level

  hpi_pin_sync #(
    .W(13),
    .INIT(13'h001F)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin({host_data_in, host_addr_bit, host_write_strobe_n, host_read_strobe_n,
          host_select_b_n, host_select_a_n}),
    .level(pins_f)
  );

  assign sel_a_n_f = pins_f[0];
  assign sel_b_n_f = pins_f[1];
  assign rd_n_f = pins_f[2];
  assign wr_n_f = pins_f[3];
  assign addr_f = pins_f[4];
  assign data_f = pins_f[12:5];

  // strobe history for edge detection
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end
    else
    begin
      rd_prev_q <= rd_n_f;
      wr_prev_q <= wr_n_f;
    end
  end

  // host access to one register pair, gated by slave mode
  function automatic logic host_hit(input logic edge_seen, input logic sel_n,
                                    input logic en);
    host_hit = edge_seen & ~sel_n & en;
  endfunction

  // ==========================================
  // control register
  logic [7:0] ctrl_q;  // slave writes steer the block
  logic slave_en;
  logic fast_en;
  logic en_a;
  logic en_b;

  assign slave_en = ctrl_q[hpi_pkg::CTRL_SLAVE_EN];
  assign fast_en = ctrl_q[hpi_pkg::CTRL_FAST_GATE] & slave_en;
  assign en_a = ctrl_q[hpi_pkg::CTRL_IRQ_EN_A];
  assign en_b = ctrl_q[hpi_pkg::CTRL_IRQ_EN_B];

  // slave strobes per register
  logic wr_ctrl;
  logic wr_port4;
  logic wr_evt;
  logic wr_mask;
  logic rd_in_a;
  logic rd_in_b;
  logic rd_port4;

  assign wr_ctrl = reg_wr & (reg_addr == hpi_pkg::ADDR_CTRL);
  assign wr_port4 = reg_wr & (reg_addr == hpi_pkg::ADDR_PORT4);
  assign wr_evt = reg_wr & (reg_addr == hpi_pkg::ADDR_EVT);
  assign wr_mask = reg_wr & (reg_addr == hpi_pkg::ADDR_MASK);
  assign rd_in_a = reg_rd & (reg_addr == hpi_pkg::ADDR_IN_A);
  assign rd_in_b = reg_rd & (reg_addr == hpi_pkg::ADDR_IN_B);
  assign rd_port4 = reg_rd & (reg_addr == hpi_pkg::ADDR_PORT4);

  // control storage
  always_ff @(posedge clk)
  begin
    if (!nrst)
      ctrl_q <= hpi_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= reg_wdata;
  end

  // ==========================================
  // host strobe decode
  logic rd_fall;  // read strobe went low
  logic wr_rise;  // write strobe went high
  logic host_wr_a;
  logic host_wr_b;
  logic host_rd_out_a;
  logic host_rd_out_b;
  logic swallow_a;  // byte taken by the gate sequencer

  assign rd_fall = rd_prev_q & ~rd_n_f;
  assign wr_rise = ~wr_prev_q & wr_n_f;
  assign host_wr_a = host_hit(wr_rise, sel_a_n_f, slave_en);
  assign host_wr_b = host_hit(wr_rise, sel_b_n_f, slave_en);
  // clear at the falling read edge, address bit low
  assign host_rd_out_a = host_hit(rd_fall, sel_a_n_f | addr_f, slave_en);
  assign host_rd_out_b = host_hit(rd_fall, sel_b_n_f | addr_f, slave_en);

  // ==========================================
  // host input data registers
  logic [7:0] host_input_reg_a_q;
  logic [7:0] host_input_reg_b_q;

  // capture data at the write's rising edge
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      host_input_reg_a_q <= 8'h00;
      host_input_reg_b_q <= 8'h00;
    end
    else
    begin
      if (host_wr_a)
        host_input_reg_a_q <= data_f;
      if (host_wr_b)
        host_input_reg_b_q <= data_f;
    end
  end

  // fast gate sequencer watches the first input register
  hpi_gate_seq u_gate (
    .clk(clk),
    .nrst(nrst),
    .enable(fast_en),
    .wr_pulse(host_wr_a),
    .is_cmd(addr_f),
    .data(data_f),
    .swallow(swallow_a),
    .gate_out(addr_gate_out)
  );

  // ==========================================
  // input-full flags
  logic full_a_q;
  logic full_b_q;

  // host write sets unless the gate sequencer swallows it, slave read clears, set wins
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      full_a_q <= 1'b0;
      full_b_q <= 1'b0;
    end
    else
    begin
      if (host_wr_a && !swallow_a)
        full_a_q <= 1'b1;
      else if (rd_in_a)
        full_a_q <= 1'b0;
      if (host_wr_b)
        full_b_q <= 1'b1;
      else if (rd_in_b)
        full_b_q <= 1'b0;
    end
  end

  // level requests to the slave cpu
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      input_full_irq_a <= 1'b0;
      input_full_irq_b <= 1'b0;
    end
    else
    begin
      input_full_irq_a <= full_a_q & en_a;
      input_full_irq_b <= full_b_q & en_b;
    end
  end

  // ==========================================
  // port four latch with host request bits
  logic [7:0] port_four_out_latch_q;
  logic [2:0] arm_q;  // bit read as zero, index 0..2 = bits 3..5
  logic [2:0] clr_host;  // host read clears per line

  assign clr_host = {host_rd_out_a, host_rd_out_a, host_rd_out_b};

  // arm on a zero read, disarm on any write
  always_ff @(posedge clk)
  begin
    if (!nrst)
      arm_q <= 3'h0;
    else if (wr_port4)
      arm_q <= 3'h0;
    else if (rd_port4)
      arm_q <= arm_q | ~port_four_out_latch_q[5:3];
  end

  // latch update: armed write of one sets over a host clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
      port_four_out_latch_q <= hpi_pkg::PORT4_RESET;
    else
    begin
      port_four_out_latch_q[2:0] <= wr_port4 ? reg_wdata[2:0] : port_four_out_latch_q[2:0];
      port_four_out_latch_q[7:6] <= wr_port4 ? reg_wdata[7:6] : port_four_out_latch_q[7:6];
      for (int i = 0; i < 3; i++)
      begin
        if (wr_port4 && reg_wdata[3+i] && (arm_q[i] || !slave_en))
          port_four_out_latch_q[3+i] <= 1'b1;
        else if (wr_port4 && !reg_wdata[3+i])
          port_four_out_latch_q[3+i] <= 1'b0;
        else if (clr_host[i])
          port_four_out_latch_q[3+i] <= 1'b0;
      end
    end
  end

  // drive request lines only in slave mode
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      host_irq_line_a <= 1'b0;
      host_irq_line_b <= 1'b0;
      host_irq_line_c <= 1'b0;
    end
    else
    begin
      host_irq_line_a <= slave_en & port_four_out_latch_q[hpi_pkg::LINE_A_BIT];
      host_irq_line_b <= slave_en & port_four_out_latch_q[hpi_pkg::LINE_B_BIT];
      host_irq_line_c <= slave_en & port_four_out_latch_q[hpi_pkg::LINE_C_BIT];
    end
  end

  // ==========================================
  // sticky events and combined interrupt
  logic [3:0] evt_q;
  logic [3:0] mask_q;
  logic [3:0] evt_set;

  assign evt_set = {host_rd_out_b, host_rd_out_a, host_wr_b, host_wr_a};

  // set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (!nrst)
      evt_q <= hpi_pkg::EVT_RESET;
    else
      evt_q <= evt_set | (evt_q & ~(wr_evt ? reg_wdata[3:0] : 4'h0));
  end

  // mask storage
  always_ff @(posedge clk)
  begin
    if (!nrst)
      mask_q <= hpi_pkg::EVT_RESET;
    else if (wr_mask)
      mask_q <= reg_wdata[3:0];
  end

  // level interrupt while any unmasked event stands
  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(evt_q & mask_q);
  end

  // ==========================================
  // read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        hpi_pkg::ADDR_CTRL: reg_rdata <= ctrl_q;
        hpi_pkg::ADDR_FLAGS: reg_rdata <= {6'h00, full_b_q, full_a_q};
        hpi_pkg::ADDR_IN_A: reg_rdata <= host_input_reg_a_q;
        hpi_pkg::ADDR_IN_B: reg_rdata <= host_input_reg_b_q;
        hpi_pkg::ADDR_PORT4: reg_rdata <= port_four_out_latch_q;
        hpi_pkg::ADDR_EVT: reg_rdata <= {4'h0, evt_q};
        hpi_pkg::ADDR_MASK: reg_rdata <= {4'h0, mask_q};
        default: reg_rdata <= 8'h00;  // unmapped reads zero
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ==========================================
  // checks
  property p_irq_a_on;
    @(posedge clk) disable iff (!nrst)
    (full_a_q && en_a) |=> input_full_irq_a;
  endproperty
  a_irq_a_on: assert property (p_irq_a_on)
    else $error("first request missing while full and enabled");

  property p_irq_a_cause;
    @(posedge clk) disable iff (!nrst)
    input_full_irq_a |-> $past(full_a_q) && $past(en_a);
  endproperty
  a_irq_a_cause: assert property (p_irq_a_cause)
    else $error("first request without cause");

  property p_irq_b_cause;
    @(posedge clk) disable iff (!nrst)
    input_full_irq_b |-> $past(full_b_q) && $past(en_b);
  endproperty
  a_irq_b_cause: assert property (p_irq_b_cause)
    else $error("second request without cause");

  property p_irq_level;
    @(posedge clk) disable iff (!nrst)
    (full_b_q && en_b) [*3] |-> ##0 input_full_irq_b ##1 (input_full_irq_b || !$past(full_b_q)
                                                           || !$past(en_b));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("second request dropped while cause stands");

  property p_full_set;
    @(posedge clk) disable iff (!nrst)
    (host_wr_b) |=> full_b_q;
  endproperty
  a_full_set: assert property (p_full_set)
    else $error("host write did not set full flag");

  property p_full_clr;
    @(posedge clk) disable iff (!nrst)
    (rd_in_a && !host_wr_a) |=> !full_a_q ##1 1'b1;
  endproperty
  a_full_clr: assert property (p_full_clr)
    else $error("slave read did not clear full flag");

  property p_host_clear;
    @(posedge clk) disable iff (!nrst)
    (host_rd_out_a && !wr_port4) |=> !port_four_out_latch_q[4] && !port_four_out_latch_q[5];
  endproperty
  a_host_clear: assert property (p_host_clear)
    else $error("host read did not clear latches");

  property p_set_armed;
    @(posedge clk) disable iff (!nrst)
    (slave_en && $rose(port_four_out_latch_q[3])) |-> $past(arm_q[0]);
  endproperty
  a_set_armed: assert property (p_set_armed)
    else $error("latch set without a preceding zero read");

  property p_lines_off;
    @(posedge clk) disable iff (!nrst)
    !slave_en |=> !host_irq_line_a && !host_irq_line_b && !host_irq_line_c;
  endproperty
  a_lines_off: assert property (p_lines_off)
    else $error("host line driven outside slave mode");

  c_irq_a: cover property (@(posedge clk) disable iff (!nrst) $rose(input_full_irq_a));
  c_line_c: cover property (@(posedge clk) disable iff (!nrst) $fell(host_irq_line_c));
  c_irq: cover property (@(posedge clk) disable iff (!nrst) $rose(irq));

endmodule : hpi_port
`default_nettype wire

// ---- tb.sv ----
// self-checking bench of the host port interrupt block
// assumes hpi_port, hpi_pkg and the host model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
  // ==========================================
  // clock, reset and slave bus
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  // host pins
  logic sel_a_n;
  logic sel_b_n;
  logic addr_bit;
  logic rd_n;
  logic wr_n;
  logic [7:0] hdata;
  // outputs to the slave and host
  logic irq_a;
  logic irq_b;
  logic irq;
  logic line_a;
  logic line_b;
  logic line_c;
  logic gate;
  logic [7:0] outs;
  int failures = 0;
  int n_checks = 0;

  // packed view: irq_a irq_b irq line_a line_b line_c gate
  assign outs = {1'b0, irq_a, irq_b, irq, line_a, line_b, line_c, gate};
  always #10 clk = ~clk;

  hpi_port i_hpi_port (.clk(clk), .nrst(nrst), .host_select_a_n(sel_a_n),
    .host_select_b_n(sel_b_n), .host_addr_bit(addr_bit), .host_read_strobe_n(rd_n),
    .host_write_strobe_n(wr_n), .host_data_in(hdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_full_irq_a(irq_a), .input_full_irq_b(irq_b), .irq(irq),
    .host_irq_line_a(line_a), .host_irq_line_b(line_b), .host_irq_line_c(line_c),
    .addr_gate_out(gate));
  hpi_host_model host (.clk(clk), .sel_a_n(sel_a_n), .sel_b_n(sel_b_n),
    .addr_bit(addr_bit), .rd_n(rd_n), .wr_n(wr_n), .data(hdata));

  // ==========================================
  // compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // let registered outputs settle, sample mid-cycle
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // one-cycle slave write
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle slave read, data taken in the following cycle
  task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rchk

  // ==========================================
  // scenarios
  task automatic t_reset();
    @(negedge clk);
    chk(outs, 8'h01);
    rchk(hpi_pkg::ADDR_CTRL, 8'h00);
  endtask : t_reset

  // full flags, their requests and the sticky event irq
  task automatic t_full();
    wr(hpi_pkg::ADDR_CTRL, 8'h0D);
    wr(hpi_pkg::ADDR_MASK, 8'h03);
    host.xfer(1'b0, 1'b0, 1'b1, 8'h5A);
    settle();
    chk(outs, 8'h51);
    rchk(hpi_pkg::ADDR_FLAGS, 8'h01);
    rchk(hpi_pkg::ADDR_IN_A, 8'h5A);
    settle();
    chk(outs, 8'h11);
    wr(hpi_pkg::ADDR_EVT, 8'h01);
    settle();
    chk(outs, 8'h01);
    // second pair with its enable off first
    wr(hpi_pkg::ADDR_CTRL, 8'h05);
    host.xfer(1'b1, 1'b0, 1'b1, 8'hA5);
    settle();
    chk(outs, 8'h11);
    wr(hpi_pkg::ADDR_CTRL, 8'h0D);
    settle();
    chk(outs, 8'h31);
    rchk(hpi_pkg::ADDR_IN_B, 8'hA5);
    wr(hpi_pkg::ADDR_EVT, 8'h0F);
    settle();
    chk(outs, 8'h01);
    rchk(5'h1C, 8'h00);
  endtask : t_full

  // arm by read-zero then write-one of all three latches
  task automatic arm();
    rchk(hpi_pkg::ADDR_PORT4, 8'h00);
    wr(hpi_pkg::ADDR_PORT4, 8'h38);
    settle();
  endtask : arm

  task automatic t_latch();
    wr(hpi_pkg::ADDR_PORT4, 8'h38);
    settle();
    chk(outs, 8'h01);
    arm();
    chk(outs, 8'h0F);
    host.xfer(1'b0, 1'b1, 1'b0, 8'h00);
    chk(outs, 8'h0F);
    host.xfer(1'b0, 1'b0, 1'b0, 8'h00);
    chk(outs, 8'h05);
    host.xfer(1'b1, 1'b0, 1'b0, 8'h00);
    chk(outs, 8'h01);
    rchk(hpi_pkg::ADDR_EVT, 8'h0C);
    arm();
    wr(hpi_pkg::ADDR_PORT4, 8'h00);
    settle();
    chk(outs, 8'h01);
  endtask : t_latch

  task automatic t_off();
    wr(hpi_pkg::ADDR_CTRL, 8'h00);
    // outside slave mode the latch stores plainly and drives no line
    wr(hpi_pkg::ADDR_PORT4, 8'h38);
    settle();
    chk(outs, 8'h01);
    rchk(hpi_pkg::ADDR_PORT4, 8'h38);
    host.xfer(1'b0, 1'b0, 1'b1, 8'h33);
    rchk(hpi_pkg::ADDR_FLAGS, 8'h00);
  endtask : t_off

  // gate command then data, gate follows data bit 1 only
  task automatic t_gate();
    logic [7:0] tbl [4];
    tbl = '{8'h00, 8'h02, 8'hFD, 8'hFE};
    wr(hpi_pkg::ADDR_CTRL, 8'h03);
    foreach (tbl[i])
    begin
      host.xfer(1'b0, 1'b1, 1'b1, hpi_pkg::CMD_GATE);
      host.xfer(1'b0, 1'b0, 1'b1, tbl[i]);
      chk({7'h00, gate}, {7'h00, tbl[i][1]});
    end
    rchk(hpi_pkg::ADDR_FLAGS, 8'h00);
  endtask : t_gate

  // ==========================================
  // verdict and end of run
  task automatic summarize();
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    t_reset();
    t_full();
    t_latch();
    t_off();
    t_gate();
    summarize();
  end

  // watchdog well past the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule : tb
`default_nettype wire
